// ### pwla_top.sv
// command write lock, slave address matching and per-channel option logic
// assumes a bus framer on core_clk delivering decoded address, write and read requests
`timescale 1ns/10ps
module pwla_top
   import pwla_pkg::*;
#(
   parameter int NCH         = 2,
   parameter int MIN_OFF_CYC = pwla_pkg::MIN_OFF_CYC
) (
   input  wire logic           core_clk,
   input  wire logic           rst_n,
   input  wire logic           lock_pin,
   input  wire logic           addr_select_pin,
   input  wire logic           addr_select_open,
   input  wire logic           shared_timebase,
   input  wire logic           gpio_low,
   input  wire logic           scl_in,
   input  wire logic           sda_in,
   input  wire logic [7:0]     nvm_slave_addr,
   input  wire logic           addr_req,
   input  wire logic [6:0]     addr_byte,
   input  wire logic           cmd_wr,
   input  wire logic           cmd_rd,
   input  wire logic [7:0]     cmd_code,
   input  wire logic [7:0]     cmd_data,
   input  wire logic           rail_rd_active,
   input  wire logic           sda_drive_low,
   input  wire logic [NCH-1:0] run_cmd,
   input  wire logic [NCH-1:0] off_seq_busy,
   input  wire logic [NCH-1:0] out_decayed,
   output logic                addr_ack,
   output logic                addr_hit,
   output logic                addr_rail,
   output logic                addr_chan,
   output logic                wr_done,
   output logic                wr_refused,
   output logic                fwd_wr,
   output logic [7:0]          fwd_code,
   output logic [7:0]          fwd_data,
   output logic                rd_valid,
   output logic                rd_own,
   output logic [7:0]          rd_data,
   output logic                comm_fault,
   output logic [NCH-1:0]      pwm_enable,
   output logic [NCH-1:0]      fast_off,
   output logic [NCH-1:0]      enable_pin_oe,
   output logic [NCH-1:0]      retry_ready,
   output logic                alert_oe
);
   localparam int CW = $clog2(MIN_OFF_CYC + 1);
   localparam int PW = $clog2(RUN_PULSE_CYC + 1);
   localparam logic [CW-1:0] MIN_LD = CW'(MIN_OFF_CYC);
   localparam logic [PW-1:0] PUL_LD = PW'(RUN_PULSE_CYC);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (NCH != 2)
      $error("pwla_top: page decode serves exactly two channels");
   if (MIN_OFF_CYC < 1)
      $error("pwla_top: minimum off count must be at least one");

   typedef struct packed {
      logic [7:0]               lock_lvl;
      logic [7:0]               slave;
      logic [NCH-1:0][7:0]      rail;
      logic [NCH-1:0][7:0]      chan_opt;
      logic [7:0]               glob_opt;
      logic [7:0]               page;
      logic                     addr_ack;
      logic                     addr_hit;
      logic                     addr_rail;
      logic                     addr_chan;
      logic                     wr_done;
      logic                     wr_refused;
      logic                     fwd_wr;
      logic [7:0]               fwd_code;
      logic [7:0]               fwd_data;
      logic                     rd_valid;
      logic                     rd_own;
      logic [7:0]               rd_data;
      logic                     comm_fault;
      logic                     scl_q;
      pwla_ch_t [NCH-1:0]       ch_state;
      logic [NCH-1:0][CW-1:0]   min_cnt;
      logic [NCH-1:0][PW-1:0]   pul_cnt;
      logic [NCH-1:0]           pwm_en;
      logic [NCH-1:0]           fast_off;
      logic [NCH-1:0]           run_oe;
      logic [NCH-1:0]           retry_ok;
      logic                     alert_oe;
   } pwla_state_t;

   pwla_state_t s_r;
   pwla_state_t s_nxt;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [6:0] pin_s;
   logic       lock_s;
   logic       addr_select_pin_s;
   logic       aopen_s;
   logic       tbase_s;
   logic       gpio_s;
   logic       scl_s;
   logic       sda_s;

   pwla_sync #(.W(7)) u_sync (
      .clk   (core_clk),
      .rst_n (rst_n),
      .d     ({lock_pin, addr_select_pin, addr_select_open, shared_timebase,
               gpio_low, scl_in, sda_in}),
      .q     (pin_s)
   );
   assign {lock_s, addr_select_pin_s, aopen_s, tbase_s, gpio_s, scl_s, sda_s} = pin_s;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // intersection of level and pin sets gives the stricter restriction
   function automatic logic lock_ok(input logic [7:0] code, input logic [7:0] lvl,
                                    input logic pin);
      logic st;
      logic base;
      logic lv;
      logic pn;
      st   = (code >= C_STATUS_LO) && (code <= C_STATUS_HI);
      base = (code == C_LOCK) || (code == C_PAGE) || (code == C_UNLOCK) ||
             (code == C_PEAK) || (code == C_SAVE) || (code == C_OPERATION) ||
             (code == C_CLEAR) || st;
      lv   = 1'b1;
      if (lvl[LOCK_B_ALL])
         lv = (code == C_LOCK) || (code == C_PAGE) || (code == C_UNLOCK) ||
              (code == C_SAVE);
      else if (lvl[LOCK_B_CTRL])
         lv = base;
      else if (lvl[LOCK_B_SET])
         lv = base || (code == C_POLICY) || (code == C_SETPOINT);
      pn = !pin || (code == C_PAGE) || (code == C_OPERATION) || (code == C_PEAK) ||
           (code == C_UNLOCK) || (code == C_CLEAR) || st;
      return lv && pn;
   endfunction

   // strap ignore bit is deliberately not consulted for the lsb
   function automatic logic [6:0] dev_addr(input logic [7:0] slv, input logic [7:0] nvm,
                                           input logic sel, input logic open);
      logic [6:0] a;
      a = {slv[6:1], sel};
      if (open)
         a = {slv[6:ADDR_SELECT_PIN_NIB], nvm[ADDR_SELECT_PIN_NIB-1:0]};
      return a;
   endfunction

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb
   begin
      logic       hit_dev;
      logic       hit_rail;
      logic [7:0] opt;
      logic [7:0] rsel;
      s_nxt = s_r;
      hit_dev  = 1'b0;
      hit_rail = 1'b0;
      opt      = '0;
      rsel     = s_r.page;
      s_nxt.addr_ack   = 1'b0;
      s_nxt.wr_done    = 1'b0;
      s_nxt.wr_refused = 1'b0;
      s_nxt.fwd_wr     = 1'b0;
      s_nxt.rd_valid   = 1'b0;
      s_nxt.comm_fault = 1'b0;
      s_nxt.scl_q      = scl_s;

      // address match: device, global, rail
      if (addr_req)
      begin
         hit_dev = (s_r.slave != ADDR_OFF) &&
                   (addr_byte == dev_addr(s_r.slave, nvm_slave_addr, addr_select_pin_s, aopen_s));
         for (int i = 0; i < NCH; i++)
            if ((s_r.rail[i] != ADDR_OFF) && (addr_byte == s_r.rail[i][6:0]))
               hit_rail = 1'b1;
         s_nxt.addr_ack  = 1'b1;
         s_nxt.addr_hit  = hit_dev || hit_rail ||
                           (addr_byte == GLOBAL_A) || (addr_byte == GLOBAL_B);
         s_nxt.addr_rail = hit_rail && !hit_dev;
         s_nxt.addr_chan = s_r.page[0];
      end

      // command writes through the lock filter
      if (cmd_wr)
      begin
         s_nxt.wr_done = 1'b1;
         if (!lock_ok(cmd_code, s_r.lock_lvl, lock_s))
         begin
            s_nxt.wr_refused = 1'b1;
            s_nxt.comm_fault = 1'b1;
         end
         else
         begin
            case (cmd_code)
               C_LOCK:     s_nxt.lock_lvl = cmd_data;
               C_SLAVE:    s_nxt.slave    = cmd_data;
               C_GLOB_OPT: s_nxt.glob_opt = cmd_data;
               C_PAGE:     s_nxt.page     = cmd_data;
               C_CHAN_OPT, C_RAIL:
               begin
                  for (int i = 0; i < NCH; i++)
                     if ((s_r.page == PAGE_ALL) || (s_r.page[0] == i[0]))
                        if (cmd_code == C_RAIL)
                           s_nxt.rail[i] = cmd_data;
                        else
                           s_nxt.chan_opt[i] = cmd_data;
               end
               default:
               begin
                  s_nxt.fwd_wr   = 1'b1;
                  s_nxt.fwd_code = cmd_code;
                  s_nxt.fwd_data = cmd_data;
               end
            endcase
         end
      end

      // reads of owned commands; page all reads channel 0
      if (cmd_rd)
      begin
         if (s_r.page == PAGE_ALL)
            rsel = PAGE_RST;
         s_nxt.rd_valid = 1'b1;
         s_nxt.rd_own   = 1'b1;
         s_nxt.rd_data  = '0;
         case (cmd_code)
            C_LOCK:     s_nxt.rd_data = s_r.lock_lvl;
            C_SLAVE:    s_nxt.rd_data = s_r.slave;
            C_GLOB_OPT: s_nxt.rd_data = s_r.glob_opt;
            C_PAGE:     s_nxt.rd_data = s_r.page;
            C_CHAN_OPT: s_nxt.rd_data = s_r.chan_opt[rsel[0]];
            C_RAIL:     s_nxt.rd_data = s_r.rail[rsel[0]];
            C_COMMON:   s_nxt.rd_data[COMMON_B_PIN] = lock_s;
            default:    s_nxt.rd_own = 1'b0;
         endcase
      end

      // released line seen low at a clock rise means another driver differs
      if (scl_s && !s_r.scl_q && rail_rd_active && !sda_drive_low && !sda_s)
         s_nxt.comm_fault = 1'b1;

      // per-channel sequencing and option bits
      s_nxt.alert_oe = 1'b0;
      for (int i = 0; i < NCH; i++)
      begin
         opt = s_r.chan_opt[i];
         if (s_r.pul_cnt[i] != '0)
            s_nxt.pul_cnt[i] = s_r.pul_cnt[i] - 1'b1;
         if (s_r.min_cnt[i] != '0)
            s_nxt.min_cnt[i] = s_r.min_cnt[i] - 1'b1;
         unique case (s_r.ch_state[i])
            CH_ON:
               if (!run_cmd[i])
               begin
                  s_nxt.ch_state[i] = CH_OFF;
                  if (!opt[OPT_B_RUNLOW])
                     s_nxt.pul_cnt[i] = PUL_LD;
               end
            CH_OFF:
               if (run_cmd[i])
               begin
                  if (off_seq_busy[i])
                  begin
                     if (opt[OPT_B_SHORT])
                     begin
                        s_nxt.ch_state[i] = CH_MINOFF;
                        s_nxt.min_cnt[i]  = MIN_LD;
                     end
                  end
                  else if (opt[OPT_B_DECAY] || out_decayed[i])
                     s_nxt.ch_state[i] = CH_ON;
               end
            CH_MINOFF:
               if (!run_cmd[i])
                  s_nxt.ch_state[i] = CH_OFF;
               else if (s_r.min_cnt[i] == '0)
                  s_nxt.ch_state[i] = CH_ON;
            default:
               s_nxt.ch_state[i] = CH_OFF;
         endcase
         s_nxt.pwm_en[i]   = (s_nxt.ch_state[i] == CH_ON) &&
                             !(opt[OPT_B_TBASE] && !tbase_s);
         s_nxt.fast_off[i] = (s_nxt.ch_state[i] == CH_MINOFF);
         s_nxt.run_oe[i]   = (s_nxt.pul_cnt[i] != '0);
         s_nxt.retry_ok[i] = opt[OPT_B_DECAY] || out_decayed[i];
         if (gpio_s && !opt[OPT_B_NOALRT])
            s_nxt.alert_oe = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r          <= '0;
         s_r.lock_lvl <= LOCK_RST;
         s_r.slave    <= SLAVE_RST;
         s_r.rail     <= {NCH{RAIL_RST}};
         s_r.chan_opt <= {NCH{CHAN_OPT_RST}};
         s_r.glob_opt <= GLOB_OPT_RST;
         s_r.page     <= PAGE_RST;
         s_r.ch_state <= {NCH{CH_OFF}};
      end
      else
         s_r <= s_nxt;
   end

   // outputs straight from the state register
   assign addr_ack      = s_r.addr_ack;
   assign addr_hit      = s_r.addr_hit;
   assign addr_rail     = s_r.addr_rail;
   assign addr_chan     = s_r.addr_chan;
   assign wr_done       = s_r.wr_done;
   assign wr_refused    = s_r.wr_refused;
   assign fwd_wr        = s_r.fwd_wr;
   assign fwd_code      = s_r.fwd_code;
   assign fwd_data      = s_r.fwd_data;
   assign rd_valid      = s_r.rd_valid;
   assign rd_own        = s_r.rd_own;
   assign rd_data       = s_r.rd_data;
   assign comm_fault    = s_r.comm_fault;
   assign pwm_enable    = s_r.pwm_en;
   assign fast_off      = s_r.fast_off;
   assign enable_pin_oe = s_r.run_oe;
   assign retry_ready   = s_r.retry_ok;
   assign alert_oe      = s_r.alert_oe;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_lock_all;
      cmd_wr && s_r.lock_lvl[LOCK_B_ALL] && (cmd_code == C_OPERATION) |=> wr_refused;
   endproperty
   a_lock_all: assert property (p_lock_all) else $error("operation write passed lock 0x80");

   property p_lock_ctrl;
      cmd_wr && (s_r.lock_lvl == 8'h40) && !lock_s && (cmd_code == C_SETPOINT)
         |=> wr_refused && comm_fault && !fwd_wr;
   endproperty
   a_lock_ctrl: assert property (p_lock_ctrl) else $error("setpoint write passed lock 0x40");

   property p_lock_set;
      cmd_wr && (s_r.lock_lvl == 8'h20) && !lock_s && (cmd_code == C_SETPOINT)
         |=> fwd_wr && !wr_refused;
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("setpoint write refused at 0x20");

   property p_lock_none;
      cmd_wr && (s_r.lock_lvl == LOCK_RST) && !lock_s && (cmd_code == C_CHAN_OPT)
         |=> !wr_refused ##1 (s_r.chan_opt[s_r.page[0]] == $past(cmd_data, 2));
   endproperty
   a_lock_none: assert property (p_lock_none) else $error("open lock blocked write");

   property p_pin;
      cmd_wr && lock_s && (cmd_code == C_LOCK) |=> wr_refused ##1 $stable(s_r.lock_lvl);
   endproperty
   a_pin: assert property (p_pin) else $error("lock pin did not block write");

   property p_rd_lock;
      cmd_rd && (cmd_code == C_LOCK) |=> rd_valid && (rd_data == $past(s_r.lock_lvl));
   endproperty
   a_rd_lock: assert property (p_rd_lock) else $error("lock readback wrong");

   property p_global;
      addr_req && ((addr_byte == GLOBAL_A) || (addr_byte == GLOBAL_B)) |=> addr_ack && addr_hit;
   endproperty
   a_global: assert property (p_global) else $error("global address missed");

   property p_dev_off;
      addr_req && (s_r.slave == ADDR_OFF) && (addr_byte != GLOBAL_A) &&
      (addr_byte != GLOBAL_B) && (s_r.rail == {NCH{RAIL_RST}}) |=> !addr_hit;
   endproperty
   a_dev_off: assert property (p_dev_off) else $error("disabled address matched");

   property p_contend;
      scl_s && !s_r.scl_q && rail_rd_active && !sda_drive_low && !sda_s |=> comm_fault;
   endproperty
   a_contend: assert property (p_contend) else $error("rail contention not flagged");

   property p_no_pulse;
      s_r.chan_opt[0][OPT_B_RUNLOW] && (s_r.ch_state[0] == CH_ON) |=> !enable_pin_oe[0];
   endproperty
   a_no_pulse: assert property (p_no_pulse) else $error("enable pin pulsed with bit 4 set");

   sequence s_short_entry;
      (s_r.ch_state[0] == CH_OFF) && run_cmd[0] && off_seq_busy[0] &&
      s_r.chan_opt[0][OPT_B_SHORT];
   endsequence
   property p_short;
      s_short_entry |=> fast_off[0] && !pwm_enable[0];
   endproperty
   a_short: assert property (p_short) else $error("short cycle did not force off");

   property p_tbase;
      s_r.chan_opt[0][OPT_B_TBASE] && !tbase_s |=> !pwm_enable[0];
   endproperty
   a_tbase: assert property (p_tbase) else $error("output on with timebase low");

   property p_alert;
      gpio_s && (s_r.chan_opt == {NCH{8'h02}}) |=> !alert_oe;
   endproperty
   a_alert: assert property (p_alert) else $error("alert pulled with bit 1 set");

   property p_decay;
      (s_r.ch_state[0] == CH_OFF) && !s_r.chan_opt[0][OPT_B_DECAY] && !out_decayed[0]
         |=> (s_r.ch_state[0] != CH_ON) && !retry_ready[0];
   endproperty
   a_decay: assert property (p_decay) else $error("restart without output decay");
endmodule

// ### pwla_pkg.sv
// constants and types for the write-lock, addressing and channel option block
// assumes a 50 MHz core clock and an 8-bit command code from the bus framer
package pwla_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int MIN_OFF_MS    = 120;
   localparam int MIN_OFF_CYC   = (MIN_OFF_MS * 1000000) / CLK_PERIOD_NS;
   localparam int RUN_PULSE_NS  = 10000;
   localparam int RUN_PULSE_CYC = RUN_PULSE_NS / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] C_PAGE      = 8'h00;
   localparam logic [7:0] C_OPERATION = 8'h01;
   localparam logic [7:0] C_POLICY    = 8'h02;
   localparam logic [7:0] C_CLEAR     = 8'h03;
   localparam logic [7:0] C_LOCK      = 8'h10;
   localparam logic [7:0] C_SAVE      = 8'h15;
   localparam logic [7:0] C_SETPOINT  = 8'h21;
   localparam logic [7:0] C_STATUS_LO = 8'h78;
   localparam logic [7:0] C_STATUS_HI = 8'h80;
   localparam logic [7:0] C_CHAN_OPT  = 8'hD0;
   localparam logic [7:0] C_GLOB_OPT  = 8'hD1;
   localparam logic [7:0] C_PEAK      = 8'hE3;
   localparam logic [7:0] C_SLAVE     = 8'hE6;
   localparam logic [7:0] C_COMMON    = 8'hEF;
   localparam logic [7:0] C_UNLOCK    = 8'hBD;
   localparam logic [7:0] C_RAIL      = 8'hFA;

   // ---------------------------------------------------------------
   // values, reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] LOCK_RST     = 8'h00;
   localparam logic [7:0] SLAVE_RST    = 8'h4F;
   localparam logic [7:0] RAIL_RST     = 8'h80;
   localparam logic [7:0] CHAN_OPT_RST = 8'h1F;
   localparam logic [7:0] GLOB_OPT_RST = 8'h09;
   localparam logic [7:0] PAGE_RST     = 8'h00;
   localparam logic [7:0] PAGE_ALL     = 8'hFF;
   localparam logic [7:0] ADDR_OFF     = 8'h80;
   localparam logic [6:0] GLOBAL_A     = 7'h5A;
   localparam logic [6:0] GLOBAL_B     = 7'h5B;
   localparam int LOCK_B_ALL   = 7;
   localparam int LOCK_B_CTRL  = 6;
   localparam int LOCK_B_SET   = 5;
   localparam int OPT_B_RUNLOW = 4;
   localparam int OPT_B_SHORT  = 3;
   localparam int OPT_B_TBASE  = 2;
   localparam int OPT_B_NOALRT = 1;
   localparam int OPT_B_DECAY  = 0;
   localparam int COMMON_B_PIN = 2;
   localparam int ADDR_SELECT_PIN_NIB     = 4;

   // per-channel sequencing state
   typedef enum logic [2:0] {
      CH_OFF    = 3'b001,
      CH_ON     = 3'b010,
      CH_MINOFF = 3'b100
   } pwla_ch_t;

endpackage

// ### pwla_sync.sv
// two-stage synchroniser for a group of asynchronous pin levels
// assumes levels only: no pulse shorter than two clocks must be caught
`timescale 1ns/10ps
module pwla_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pwla_sync_t;

   pwla_sync_t s_r;
   pwla_sync_t s_nxt;

   // first stage feeds only the second
   always_comb
   begin
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign q = s_r.s2;
endmodule

// ### pwla_host.sv
// bus host model: clocks one frame of low data bits
// assumes released lines sit at pull-up level
`timescale 1ns/10ps
module pwla_host (
   input  wire logic go,
   output logic      scl,
   output logic      sda
);
   // clock only runs within the frame
   initial
   begin
      {scl, sda} = 2'h3;
      @(posedge go);
      repeat (8) #80 {scl, sda} = {~scl, 1'h0};
      {scl, sda} = 2'h3; // released: pull-ups win
   end
endmodule

// ### test_pwla_top.sv
// bench: lock levels, lock pin, address match, options
// assumes pwla_pkg, pwla_top and pwla_host compiled first
`timescale 1ns/10ps
module test_pwla_top import pwla_pkg::*; ;
   logic core_clk, rst_n, lock_pin, addr_select_pin, addr_select_open, shared_timebase, gpio_low;
   logic scl_in, sda_in, addr_req, cmd_wr, cmd_rd, rail_rd_active, sda_drive_low, go, addr_ack;
   logic addr_hit, addr_rail, addr_chan, wr_done, wr_refused, fwd_wr, rd_valid, rd_own;
   logic comm_fault, alert_oe;
   logic [6:0] addr_byte;
   logic [7:0] nvm_slave_addr, cmd_code, cmd_data, fwd_code, fwd_data, rd_data;
   logic [1:0] run_cmd, off_seq_busy, out_decayed, pwm_enable, fast_off, enable_pin_oe, retry_ready;
   int         fails, compares;
   pwla_host host (.go(go), .scl(scl_in), .sda(sda_in));
   pwla_top #(.MIN_OFF_CYC(20)) DUT ( // short min-off keeps run brief
      .core_clk(core_clk), .rst_n(rst_n), .lock_pin(lock_pin),
      .addr_select_pin(addr_select_pin), .addr_select_open(addr_select_open),
      .shared_timebase(shared_timebase), .gpio_low(gpio_low), .scl_in(scl_in),
      .sda_in(sda_in), .nvm_slave_addr(nvm_slave_addr), .addr_req(addr_req),
      .addr_byte(addr_byte), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
      .cmd_data(cmd_data), .rail_rd_active(rail_rd_active), .sda_drive_low(sda_drive_low),
      .run_cmd(run_cmd), .off_seq_busy(off_seq_busy), .out_decayed(out_decayed),
      .addr_ack(addr_ack), .addr_hit(addr_hit), .addr_rail(addr_rail),
      .addr_chan(addr_chan), .wr_done(wr_done), .wr_refused(wr_refused),
      .fwd_wr(fwd_wr), .fwd_code(fwd_code), .fwd_data(fwd_data), .rd_valid(rd_valid),
      .rd_own(rd_own), .rd_data(rd_data), .comm_fault(comm_fault),
      .pwm_enable(pwm_enable), .fast_off(fast_off), .enable_pin_oe(enable_pin_oe),
      .retry_ready(retry_ready), .alert_oe(alert_oe)
   );
   initial forever #10 core_clk = ~core_clk; // 50 MHz
   task chk(input logic [7:0] s, e);
      compares++;
      if (s !== e) fails++;
      if (s !== e) $display("[ERR] %0t got %h want %h", $time, s, e);
   endtask
   // one request: k 0 write, 1 read, 2 address
   task op(input int k, input logic [7:0] c, d, e);
      @(posedge core_clk);
      {addr_req, cmd_rd, cmd_wr} <= 3'h1 << k;
      {cmd_code, cmd_data, addr_byte} <= {c, d, c[6:0]};
      @(posedge core_clk);
      {addr_req, cmd_rd, cmd_wr} <= 3'h0;
      #1;
      chk(k == 1 ? rd_data : {6'h00, k == 0 ? {wr_refused, comm_fault} : {addr_ack, addr_hit}}, e);
   endtask
   task report_and_stop(input int extra);
      fails += extra;
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task t_lock; // levels 0x80 and 0x40: one allowed, one refused; 0x20: one allowed
      op(1, C_CHAN_OPT, 0, 8'h1F);
      op(0, C_LOCK, 8'h80, 0);
      op(0, C_OPERATION, 8'h80, 3);
      op(0, C_SAVE, 0, 0);
      op(0, C_LOCK, 8'h40, 0);
      op(0, C_CLEAR, 0, 0);
      op(0, C_GLOB_OPT, 0, 3);
      op(0, C_LOCK, 8'h20, 0);
      op(0, C_POLICY, 8'h1F, 0);
   endtask
   task t_pin; // the read also lets the pin sync settle
      @(posedge core_clk) lock_pin <= 1'h1;
      op(1, C_LOCK, 0, 8'h20);
      op(0, C_OPERATION, 8'h80, 0);
      op(0, C_POLICY, 8'h1F, 3);
      op(0, C_LOCK, 8'h80, 3);
      @(posedge core_clk) lock_pin <= 1'h0;
      op(1, C_GLOB_OPT, 0, 8'h09);
      op(0, C_LOCK, 0, 0);
      op(0, C_CHAN_OPT, 8'h1F, 0);
   endtask
   task t_addr; // select pin low moves the address lsb
      @(posedge core_clk) addr_select_pin <= 1'h0;
      op(2, 8'h5B, 0, 3);
      op(2, 8'h4E, 0, 3);
      op(0, C_SLAVE, 8'h80, 0);
      op(2, 8'h4E, 0, 2);
      op(0, C_RAIL, 8'h33, 0);
      op(2, 8'h33, 0, 3);
      op(0, C_RAIL, 8'h80, 0);
      op(2, 8'h33, 0, 2);
   endtask
   task t_chan; // options at reset value 0x1F, then 0x1D on channel 0
      @(posedge core_clk) {run_cmd, gpio_low} <= 3'h3;
      repeat (4) @(posedge core_clk);
      #1 chk(pwm_enable, 2'h1);
      @(posedge core_clk) shared_timebase <= 1'h0;
      repeat (4) @(posedge core_clk);
      #1 chk({pwm_enable, alert_oe}, 3'h0);
      @(posedge core_clk) run_cmd <= 2'h0;
      repeat (3) @(posedge core_clk);
      #1 chk(enable_pin_oe, 2'h0);
      // on request during soft off: forced off, min off, then on
      @(posedge core_clk) {run_cmd, off_seq_busy, shared_timebase} <= 5'hB;
      repeat (3) @(posedge core_clk);
      #1 chk({fast_off, pwm_enable}, 4'h4);
      @(posedge core_clk) off_seq_busy <= 2'h0;
      repeat (30) @(posedge core_clk);
      #1 chk({fast_off, pwm_enable}, 4'h1);
      op(0, C_CHAN_OPT, 8'h1D, 0);
      repeat (2) @(posedge core_clk);
      #1 chk(alert_oe, 1'h1);
   endtask
   task t_bus; // rail read with our data line released
      logic s;
      s = 1'h0;
      @(posedge core_clk) {rail_rd_active, go} <= 2'h3;
      repeat (60) @(posedge core_clk) s = s | (comm_fault === 1'h1);
      chk({7'h00, s}, 8'h01);
   endtask
   // reset, then scenarios in turn
   initial
   begin
      {core_clk, rst_n, lock_pin, addr_select_open, gpio_low, go, rail_rd_active} = '0;
      {sda_drive_low, addr_req, cmd_wr, cmd_rd, addr_byte, cmd_code, cmd_data} = '0;
      {run_cmd, off_seq_busy, out_decayed, fails, compares} = '0;
      {addr_select_pin, shared_timebase, nvm_slave_addr} = {2'h3, 8'h4F};
      repeat (3) @(posedge core_clk);
      rst_n <= 1'h1;
      t_lock;
      t_pin;
      t_addr;
      t_chan;
      t_bus;
      report_and_stop(0);
   end
   initial #100000 report_and_stop(1); // hang guard: run needs ~200 cycles
endmodule
